// [logic/kasd_dec_if.sv]
interface kasd_dec_if;
  import kasd_pkg::*;
  logic [VA_W-1:0] va;
  logic            kx;
  kasd_seg_t       seg;
  logic            phys_err;
  logic [1:0]      uc_attr;
  modport dec (input va, input kx, output seg);
  modport chk (input va, output phys_err, output uc_attr);
  modport top (output va, output kx, input seg, input phys_err, input uc_attr);
endinterface

// [logic/kasd_decoder.sv]
// Implementation choices: register access over APB and the register offsets.
module kasd_decoder #(
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [ADDR_W-1:0]         paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      req_valid,
  input  wire logic [kasd_pkg::VA_W-1:0] req_vaddr,
  output logic                           res_valid,
  output logic                           res_mapped,
  output logic [kasd_pkg::PA_W-1:0]      res_paddr,
  output logic [kasd_pkg::CCA_W-1:0]     res_cca,
  output logic [1:0]                     res_uc_attr,
  output logic [kasd_pkg::SPACE_ID_TAG_W-1:0]    res_space_id,
  output logic                           res_addr_err,
  output kasd_pkg::kasd_seg_t            res_segment
);
  import kasd_pkg::*;

  kasd_dec_if dec_bus ();

  kasd_seg_decode u_seg (
    .bus (dec_bus.dec)
  );

  kasd_phys_check u_phys (
    .bus (dec_bus.chk)
  );

  logic [31:0]      ctrl_reg;
  logic             err_seen_reg;
  logic [VA_W-1:0]  err_va_reg;
  logic [31:0]      prdata_reg;
  logic             pready_reg;
  logic             pslverr_reg;
  logic             res_valid_reg;
  logic             res_mapped_reg;
  logic [PA_W-1:0]  res_paddr_reg;
  logic [CCA_W-1:0] res_cca_reg;
  logic [1:0]       res_uc_attr_reg;
  logic [SPACE_ID_TAG_W-1:0] res_space_id_reg;
  logic             res_addr_err_reg;
  kasd_seg_t        res_segment_reg;

  // Mode bits held in the control register
  wire              kx;
  wire              ux;
  wire              sx;
  wire              error_level_flag;
  wire [CCA_W-1:0]  k0;
  wire [SPACE_ID_TAG_W-1:0] space_id_tag;

  assign kx           = ctrl_reg[KX_BIT];
  assign ux           = ctrl_reg[UX_BIT];
  assign sx           = ctrl_reg[SX_BIT];
  assign error_level_flag          = ctrl_reg[ERL_BIT];
  assign k0           = ctrl_reg[K0_LSB +: CCA_W];
  assign space_id_tag = ctrl_reg[SPACE_ID_TAG_LSB +: SPACE_ID_TAG_W];

  assign dec_bus.va = req_vaddr;
  assign dec_bus.kx = kx;

  // Result selection for the decoded segment
  wire kasd_seg_t  seg;
  wire             in_xuser;
  wire             in_low32;
  wire             low_uc;
  wire             erl_low;
  wire             xuser_full;
  wire             xuser_err;
  wire             xsupv_err;
  wire             xker_err;
  wire             seg_err;
  wire             unmapped;
  wire [31:0]      low_base;
  wire [31:0]      low_pa;
  wire [PA_W-1:0]  pa_next;
  wire [CCA_W-1:0] cca_next;
  wire [1:0]       uc_next;

  assign seg        = dec_bus.seg;
  assign in_xuser   = (seg == SEG_XUSER);
  assign low_uc     = (seg == SEG_LOW_UNCACHED);
  assign in_low32   = (seg == SEG_LOW_DIRECT) || low_uc;
  assign xuser_full = ux && !error_level_flag;
  // Narrow user access must stay below the 2 GB line
  assign xuser_err  = xuser_full ? (|req_vaddr[61:44]) : (|req_vaddr[61:31]);
  assign erl_low    = error_level_flag && (in_xuser || seg == SEG_USER32);
  assign xsupv_err  = !sx || (|req_vaddr[61:44]);
  assign xker_err   = |req_vaddr[61:44];
  assign seg_err    = (in_xuser && xuser_err)
                   || (seg == SEG_XSUPV && xsupv_err)
                   || (seg == SEG_XPHYS && dec_bus.phys_err)
                   || (seg == SEG_XKERNEL && xker_err);
  assign unmapped   = in_low32 || (seg == SEG_XPHYS) || erl_low;
  assign low_base   = low_uc ? LOW_UNCACHED_BASE : LOW_DIRECT_BASE;
  assign low_pa     = req_vaddr[31:0] - low_base;
  assign pa_next    = (seg == SEG_XPHYS) ? req_vaddr[PA_W-1:0] :
                      erl_low  ? {9'h000, req_vaddr[30:0]} :
                      in_low32 ? {8'h00, low_pa} :
                      {PA_W{1'b0}};
  assign cca_next   = (seg == SEG_XPHYS) ? req_vaddr[61:59] :
                      (seg == SEG_LOW_DIRECT) ? k0 :
                      (low_uc || erl_low) ? CCA_UNCACHED :
                      CCA_NONE;
  assign uc_next    = (seg == SEG_XPHYS) ? dec_bus.uc_attr : 2'h0;

  // Registered result, one per request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      res_valid_reg    <= 1'b0;
      res_mapped_reg   <= 1'b0;
      res_paddr_reg    <= {PA_W{1'b0}};
      res_cca_reg      <= CCA_NONE;
      res_uc_attr_reg  <= 2'h0;
      res_space_id_reg <= {SPACE_ID_TAG_W{1'b0}};
      res_addr_err_reg <= 1'b0;
      res_segment_reg  <= SEG_NONE;
    end else begin
      res_valid_reg    <= req_valid;
      res_mapped_reg   <= req_valid && !unmapped;
      res_paddr_reg    <= pa_next;
      res_cca_reg      <= cca_next;
      res_uc_attr_reg  <= uc_next;
      res_space_id_reg <= space_id_tag;
      res_addr_err_reg <= req_valid && seg_err;
      res_segment_reg  <= req_valid ? seg : SEG_NONE;
    end
  end

  assign res_valid    = res_valid_reg;
  assign res_mapped   = res_mapped_reg;
  assign res_paddr    = res_paddr_reg;
  assign res_cca      = res_cca_reg;
  assign res_uc_attr  = res_uc_attr_reg;
  assign res_space_id = res_space_id_reg;
  assign res_addr_err = res_addr_err_reg;
  assign res_segment  = res_segment_reg;

  // APB slave: answer in the first access cycle
  wire        apb_setup;
  wire        apb_done;
  wire        apb_wr;
  wire [11:0] reg_ofs;
  wire        sel_ctrl;
  wire        sel_stat;
  wire        sel_va_l;
  wire        sel_va_h;
  wire        sel_any;
  wire        err_clr;
  wire        err_set;
  wire [31:0] stat_word;
  wire [31:0] rdata_next;

  assign apb_setup = psel && !penable;
  assign apb_done  = psel && penable && pready_reg;
  assign apb_wr    = apb_done && pwrite && !pslverr_reg;
  assign reg_ofs   = 12'(paddr);
  assign sel_ctrl  = (reg_ofs == CTRL_OFS);
  assign sel_stat  = (reg_ofs == STAT_OFS);
  assign sel_va_l  = (reg_ofs == ERR_VA_L_OFS);
  assign sel_va_h  = (reg_ofs == ERR_VA_H_OFS);
  assign sel_any   = sel_ctrl || sel_stat || sel_va_l || sel_va_h;
  assign err_clr   = apb_wr && sel_stat && pwdata[STAT_ERR_BIT];
  assign err_set   = res_valid_reg && res_addr_err_reg;
  assign stat_word = {6'h00, res_segment_reg, 14'h0000, res_mapped_reg, err_seen_reg};
  assign rdata_next = sel_ctrl ? ctrl_reg :
                      sel_stat ? stat_word :
                      sel_va_l ? err_va_reg[31:0] :
                      sel_va_h ? err_va_reg[63:32] :
                      32'h0000_0000;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= apb_setup;
      pslverr_reg <= apb_setup && !sel_any;
      prdata_reg  <= (apb_setup && !pwrite) ? rdata_next : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET;
    end else if (apb_wr && sel_ctrl) begin
      ctrl_reg <= pwdata & CTRL_MASK;
    end
  end

  // Sticky fault flag: a new fault wins over a clear in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      err_seen_reg <= 1'b0;
    end else begin
      err_seen_reg <= err_set || (err_seen_reg && !err_clr);
    end
  end

  // Address of the most recent faulting request
  logic [VA_W-1:0] last_va_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      last_va_reg <= {VA_W{1'b0}};
      err_va_reg  <= {VA_W{1'b0}};
    end else begin
      last_va_reg <= req_vaddr;
      if (err_set) begin
        err_va_reg <= last_va_reg;
      end
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // Checks on the registered result
  AST_KX0_SUPV: assert property (@(posedge core_clk) disable iff (rst)
    req_valid && !kx && req_vaddr[31:29] == 3'h6
    |=> res_mapped && !res_addr_err && res_space_id == $past(space_id_tag))
    else $error("32-bit supervisor window not mapped");

  AST_KX0_KMAP: assert property (@(posedge core_clk) disable iff (rst)
    req_valid && !kx && req_vaddr[31:29] == 3'h7
    |=> res_mapped && !res_addr_err && res_segment == SEG_TOP_MAPPED)
    else $error("32-bit kernel top window not mapped");

  AST_XUSER_WIDE: assert property (@(posedge core_clk) disable iff (rst)
    req_valid && kx && ux && !error_level_flag && req_vaddr[63:44] == 20'h00000
    |=> res_mapped && !res_addr_err)
    else $error("Wide user region access refused");

  AST_XUSER_LIMIT: assert property (@(posedge core_clk) disable iff (rst)
    req_valid && kx && (!ux || error_level_flag) && req_vaddr[63:62] == 2'h0 && (|req_vaddr[61:31])
    |=> res_addr_err)
    else $error("Narrow user access above 2 GB not faulted");

  AST_ERL_UNMAP: assert property (@(posedge core_clk) disable iff (rst)
    req_valid && kx && error_level_flag && req_vaddr[63:31] == 33'h000000000
    |=> !res_mapped && !res_addr_err && res_cca == CCA_UNCACHED
        && res_paddr == {9'h000, $past(req_vaddr[30:0])})
    else $error("Error-level low region not unmapped uncached");

  AST_XSUPV_GATE: assert property (@(posedge core_clk) disable iff (rst)
    req_valid && kx && req_vaddr[63:62] == 2'h1
    |=> res_addr_err == ($past(!sx) || $past(|req_vaddr[61:44])))
    else $error("Wide supervisor gate wrong");

  AST_PHYS_DIRECT: assert property (@(posedge core_clk) disable iff (rst)
    req_valid && kx && req_vaddr[63:62] == 2'h2
    |=> !res_mapped && res_paddr == $past(req_vaddr[39:0]) && res_cca == $past(req_vaddr[61:59]))
    else $error("Physical window address or cache code wrong");

  AST_PHYS_UC: assert property (@(posedge core_clk) disable iff (rst)
    req_valid && kx && req_vaddr[63:62] == 2'h2 && req_vaddr[61:59] == CCA_UC_ACCEL
    |=> res_addr_err == $past(|req_vaddr[56:40]) && res_uc_attr == $past(req_vaddr[58:57]))
    else $error("Uncached physical check wrong");

  AST_PHYS_CACHED: assert property (@(posedge core_clk) disable iff (rst)
    req_valid && kx && req_vaddr[63:62] == 2'h2 && req_vaddr[61:59] == 3'h3
    |=> res_addr_err == $past(|req_vaddr[58:40]) && res_uc_attr == 2'h0)
    else $error("Cached physical check wrong");

  AST_COMPAT_ZERO: assert property (@(posedge core_clk) disable iff (rst)
    req_valid && kx && req_vaddr[63:29] == 35'h7fffffffc
    |=> !res_mapped && res_cca == $past(k0) && res_paddr == {11'h000, $past(req_vaddr[28:0])})
    else $error("First compatibility window wrong");

  AST_LOW_UNCACHED: assert property (@(posedge core_clk) disable iff (rst)
    req_valid && !kx && req_vaddr[31:29] == 3'h5
    |=> !res_mapped && res_cca == CCA_UNCACHED && res_paddr == {11'h000, $past(req_vaddr[28:0])})
    else $error("Uncached low window wrong");

  AST_ONE_RESULT: assert property (@(posedge core_clk) disable iff (rst)
    res_valid == $past(req_valid))
    else $error("Result not one per request");
endmodule

// [logic/kasd_phys_check.sv]
module kasd_phys_check (
  kasd_dec_if.chk bus
);
  import kasd_pkg::*;
  wire [CCA_W-1:0] cca;
  wire             uncached;

  assign cca = bus.va[61:59];
  assign uncached = (cca == CCA_UNCACHED) || (cca == CCA_UC_ACCEL);
  assign bus.phys_err = uncached ? (|bus.va[56:40]) : (|bus.va[58:40]);
  assign bus.uc_attr = uncached ? bus.va[58:57] : 2'h0;
endmodule

// [logic/kasd_pkg.sv]
// Behaviour
// - Low 32-bit mode, top bits 110: supervisor window, mapped, space-id tagged.
// - Low 32-bit mode, top bits 111: kernel window, mapped, space-id tagged.
// - Wide mode, 63:62=00, user-wide and no error level: user region mapped; any of bits 61:44 set faults.
// - Otherwise only the low 2 GB is allowed; anything above faults.
// - With error level set, that low 2 GB is unmapped and uncached.
// - Wide mode, 63:62=01: supervisor region mapped if supervisor-wide and bits 61:44 all clear, else faults.
// - Wide mode, 63:62=10: no translation, physical address is bits 39:0.
// - Physical window takes its cache code from bits 61:59.
// - Uncached codes 2 or 7 fault when any of bits 56:40 is set.
// - For those codes bits 58:57 pass on as uncached attribute, never faulting.
// - Any other code faults when any of bits 58:40 is set.
// - Wide mode, 63:62=11 outside compatibility windows: kernel space, mapped.
// - With bits 61:31 all ones, low bits pick one of four compatibility windows.
// - First compatibility window unmapped, cache code from the low kernel policy.
// - Second compatibility window unmapped and uncached.
// - Third compatibility window mapped as supervisor space.
// - Fourth compatibility window mapped as kernel space.
// - Direct low window: physical address is virtual minus 0x8000_0000.
// - Uncached low window: physical address is virtual minus 0xa000_0000, uncached.
package kasd_pkg;
  localparam int unsigned VA_W   = 64;
  localparam int unsigned PA_W   = 40;
  localparam int unsigned SPACE_ID_TAG_W = 8;
  localparam int unsigned CCA_W  = 3;

  localparam logic [11:0] CTRL_OFS     = 12'h000;
  localparam logic [11:0] STAT_OFS     = 12'h004;
  localparam logic [11:0] ERR_VA_L_OFS = 12'h008;
  localparam logic [11:0] ERR_VA_H_OFS = 12'h00c;

  localparam int unsigned KX_BIT   = 0;
  localparam int unsigned UX_BIT   = 1;
  localparam int unsigned SX_BIT   = 2;
  localparam int unsigned ERL_BIT  = 3;
  localparam int unsigned K0_LSB   = 4;
  localparam int unsigned SPACE_ID_TAG_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0020;
  localparam logic [31:0] CTRL_MASK  = 32'h0000_ff7f;

  localparam int unsigned STAT_ERR_BIT    = 0;
  localparam int unsigned STAT_MAPPED_BIT = 1;
  localparam int unsigned STAT_SEG_LSB    = 16;

  localparam logic [CCA_W-1:0] CCA_NONE     = 3'h0;
  localparam logic [CCA_W-1:0] CCA_UNCACHED = 3'h2;
  localparam logic [CCA_W-1:0] CCA_UC_ACCEL = 3'h7;
  localparam logic [31:0] LOW_DIRECT_BASE   = 32'h8000_0000;
  localparam logic [31:0] LOW_UNCACHED_BASE = 32'ha000_0000;

  typedef enum logic [9:0] {
    SEG_USER32       = 10'h001,
    SEG_SUPV32       = 10'h002,
    SEG_LOW_DIRECT   = 10'h004,
    SEG_LOW_UNCACHED = 10'h008,
    SEG_TOP_MAPPED   = 10'h010,
    SEG_XUSER        = 10'h020,
    SEG_XSUPV        = 10'h040,
    SEG_XPHYS        = 10'h080,
    SEG_XKERNEL      = 10'h100,
    SEG_NONE         = 10'h200
  } kasd_seg_t;

  function automatic kasd_seg_t kasd_seg32(input logic [2:0] top3);
    case (top3)
      3'h4:    kasd_seg32 = SEG_LOW_DIRECT;
      3'h5:    kasd_seg32 = SEG_LOW_UNCACHED;
      3'h6:    kasd_seg32 = SEG_SUPV32;
      3'h7:    kasd_seg32 = SEG_TOP_MAPPED;
      default: kasd_seg32 = SEG_USER32;
    endcase
  endfunction
endpackage

// [logic/kasd_seg_decode.sv]
module kasd_seg_decode (
  kasd_dec_if.dec bus
);
  import kasd_pkg::*;
  wire             compat;
  wire kasd_seg_t  seg_wide;

  // Top quarter with bits 61:31 all ones holds the compatibility windows
  assign compat = &bus.va[61:31];
  assign seg_wide = (bus.va[63:62] == 2'h0) ? SEG_XUSER :
                    (bus.va[63:62] == 2'h1) ? SEG_XSUPV :
                    (bus.va[63:62] == 2'h2) ? SEG_XPHYS :
                    compat ? kasd_seg32(bus.va[31:29]) :
                    SEG_XKERNEL;
  assign bus.seg = bus.kx ? seg_wide : kasd_seg32(bus.va[31:29]);
endmodule

// [sim/kasd_pipe_model.sv]
module kasd_pipe_model
  import kasd_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          go,
  input  wire logic [63:0]   go_va,
  output logic               req_valid,
  output logic [63:0]        req_vaddr,
  input  wire logic          res_valid,
  input  wire logic          res_mapped,
  input  wire logic [39:0]   res_paddr,
  input  wire logic [2:0]    res_cca,
  input  wire logic [1:0]    res_uc_attr,
  input  wire logic [7:0]    res_space_id,
  input  wire logic          res_addr_err,
  input  wire kasd_seg_t     res_segment,
  output logic [15:0]        cap_cnt,
  output logic [63:0]        cap_map,
  output logic [63:0]        cap_pa,
  output logic [63:0]        cap_cca,
  output logic [63:0]        cap_uc,
  output logic [63:0]        cap_sid,
  output logic [63:0]        cap_err,
  output logic [63:0]        cap_seg
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle address toggles so a stale value is never mistaken for a request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      req_valid <= 1'b0;
      req_vaddr <= '0;
      cap_cnt   <= '0;
    end else begin
      req_valid <= go;
      req_vaddr <= go ? go_va : ~req_vaddr;
      if (res_valid) begin
        cap_cnt <= cap_cnt + 16'h1;
        cap_map <= 64'(res_mapped);
        cap_pa  <= 64'(res_paddr);
        cap_cca <= 64'(res_cca);
        cap_uc  <= 64'(res_uc_attr);
        cap_sid <= 64'(res_space_id);
        cap_err <= 64'(res_addr_err);
        cap_seg <= 64'(res_segment);
      end
    end
  end
endmodule

// [sim/tb.sv]
module tb;
  import kasd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, go, req_valid, res_valid, res_mapped, res_addr_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        er;
  logic [63:0] req_vaddr, go_va, cap_map, cap_pa, cap_cca, cap_uc, cap_sid, cap_err, cap_seg;
  logic [39:0] res_paddr;
  logic [2:0]  res_cca;
  logic [1:0]  res_uc_attr;
  logic [7:0]  res_space_id;
  logic [15:0] cap_cnt;
  kasd_seg_t   res_segment;
  int          bad_count;
  int          num_checks;

  kasd_decoder u_kasd_decoder (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .req_valid, .req_vaddr, .res_valid, .res_mapped, .res_paddr, .res_cca, .res_uc_attr,
    .res_space_id, .res_addr_err, .res_segment);
  kasd_pipe_model u_kasd_pipe_model (.core_clk, .rst, .go, .go_va, .req_valid, .req_vaddr, .res_valid,
    .res_mapped, .res_paddr, .res_cca, .res_uc_attr, .res_space_id, .res_addr_err, .res_segment, .cap_cnt,
    .cap_map, .cap_pa, .cap_cca, .cap_uc, .cap_sid, .cap_err, .cap_seg);

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic hang;
    bad_count++;
    complete_run();
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request holds until the rising edge that samples pready high; data taken at that edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) hang();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic set_ctrl(input logic [2:0] k0, input logic [3:0] m);
    apb(1'b1, CTRL_OFS, {16'h0, 8'h5a, 1'b0, k0, m});
  endtask

  task automatic wait_res(input logic [15:0] c0);
    int n;
    for (n = 0; n < 20; n++) begin
      @(negedge core_clk);
      if (cap_cnt != c0) break;
    end
    if (n == 20) hang();
  endtask

  task automatic req(input logic [63:0] va, input logic m, input logic [39:0] pa, input logic [2:0] c,
                     input logic e, input kasd_seg_t s);
    logic [15:0] c0;
    c0 = cap_cnt;
    @(posedge core_clk);
    go <= 1'b1;
    go_va <= va;
    @(posedge core_clk);
    go <= 1'b0;
    wait_res(c0);
    chk(cap_err, 64'(e));
    if (!e) begin
      chk(cap_map, 64'(m));
      chk(cap_pa, 64'(pa));
      chk(cap_cca, 64'(c));
      chk(cap_seg, 64'(s));
    end
  endtask

  task automatic back_to_back;
    logic [15:0] c0;
    c0 = cap_cnt;
    @(posedge core_clk);
    go <= 1'b1;
    go_va <= 64'hffff_ffff_8000_0040;
    @(posedge core_clk);
    go_va <= 64'hffff_ffff_a000_0080;
    @(posedge core_clk);
    go <= 1'b0;
    wait_res(c0);
    chk(cap_pa, 64'h40);
    @(negedge core_clk);
    chk(cap_pa, 64'h80);
    chk(64'(cap_cnt - c0), 64'h2);
  endtask

  task automatic reg_access;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(64'(rd), 64'h20);
    apb(1'b0, 12'h010, 32'h0);
    chk(64'(er), 64'h1);
    apb(1'b1, CTRL_OFS, 32'hffff_ffff);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(64'(rd), 64'hff7f);
  endtask

  initial begin
    {rst, psel, penable, pwrite, go} = 5'b10000;
    paddr = '0;
    pwdata = '0;
    go_va = '0;
    bad_count = 0;
    num_checks = 0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    reg_access();
    set_ctrl(3'h3, 4'b0000);
    req(64'hffff_ffff_c000_1000, 1'b1, 40'h0, 3'h0, 1'b0, SEG_SUPV32);
    chk(cap_sid, 64'h5a);
    req(64'hffff_ffff_e000_0000, 1'b1, 40'h0, 3'h0, 1'b0, SEG_TOP_MAPPED);
    req(64'hffff_ffff_8000_1234, 1'b0, 40'h1234, 3'h3, 1'b0, SEG_LOW_DIRECT);
    req(64'hffff_ffff_a000_5678, 1'b0, 40'h5678, 3'h2, 1'b0, SEG_LOW_UNCACHED);
    set_ctrl(3'h3, 4'b0011);
    req(64'h0000_0800_0000_0000, 1'b1, 40'h0, 3'h0, 1'b0, SEG_XUSER);
    set_ctrl(3'h3, 4'b0001);
    req(64'h0000_0000_8000_0000, 1'b0, 40'h0, 3'h0, 1'b1, SEG_NONE);
    req(64'h0000_0000_7fff_fff0, 1'b1, 40'h0, 3'h0, 1'b0, SEG_XUSER);
    set_ctrl(3'h3, 4'b1011);
    req(64'h0000_0001_0000_0000, 1'b0, 40'h0, 3'h0, 1'b1, SEG_NONE);
    req(64'h0000_0000_0000_1000, 1'b0, 40'h1000, 3'h2, 1'b0, SEG_XUSER);
    set_ctrl(3'h3, 4'b0101);
    req(64'h4000_0000_0000_1000, 1'b1, 40'h0, 3'h0, 1'b0, SEG_XSUPV);
    set_ctrl(3'h3, 4'b0001);
    req(64'h4000_0000_0000_1000, 1'b0, 40'h0, 3'h0, 1'b1, SEG_NONE);
    apb(1'b0, STAT_OFS, 32'h0);
    chk(64'(rd[STAT_ERR_BIT]), 64'h1);
    apb(1'b0, ERR_VA_H_OFS, 32'h0);
    chk(64'(rd), 64'h4000_0000);
    apb(1'b1, STAT_OFS, 32'h1);
    apb(1'b0, STAT_OFS, 32'h0);
    chk(64'(rd[STAT_ERR_BIT]), 64'h0);
    // Stimulus keeps clear of reserved cache codes in the physical window
    req(64'h9000_0012_3456_7890, 1'b0, 40'h12_3456_7890, 3'h2, 1'b0, SEG_XPHYS);
    req(64'h9600_0000_0000_0040, 1'b0, 40'h40, 3'h2, 1'b0, SEG_XPHYS);
    chk(cap_uc, 64'h3);
    req(64'h9001_0000_0000_0000, 1'b0, 40'h0, 3'h0, 1'b1, SEG_NONE);
    req(64'hbc00_0100_0000_0000, 1'b0, 40'h0, 3'h0, 1'b1, SEG_NONE);
    req(64'hbc00_00ff_ffff_ffff, 1'b0, 40'hff_ffff_ffff, 3'h7, 1'b0, SEG_XPHYS);
    req(64'h9800_0000_0000_0100, 1'b0, 40'h100, 3'h3, 1'b0, SEG_XPHYS);
    req(64'h9a00_0000_0000_0000, 1'b0, 40'h0, 3'h0, 1'b1, SEG_NONE);
    req(64'hc000_0000_0000_1000, 1'b1, 40'h0, 3'h0, 1'b0, SEG_XKERNEL);
    req(64'hffff_ffff_8000_0010, 1'b0, 40'h10, 3'h3, 1'b0, SEG_LOW_DIRECT);
    req(64'hffff_ffff_a000_1000, 1'b0, 40'h1000, 3'h2, 1'b0, SEG_LOW_UNCACHED);
    req(64'hffff_ffff_c000_0000, 1'b1, 40'h0, 3'h0, 1'b0, SEG_SUPV32);
    req(64'hffff_ffff_e000_0000, 1'b1, 40'h0, 3'h0, 1'b0, SEG_TOP_MAPPED);
    back_to_back();
    complete_run();
  end
endmodule
